// ### core/chip_config_pkg.sv
// Constants and types shared by the chip configuration register bank
`default_nettype none
package chip_config_pkg;
    localparam logic [11:0] serial_port_config_addr     = 12'h000;
    localparam logic [11:0] device_identity_addr        = 12'h001;
    localparam logic [11:0] speed_grade_select_addr     = 12'h002;
    localparam logic [11:0] target_mask_upper_addr      = 12'h004;
    localparam logic [11:0] target_mask_lower_addr      = 12'h005;
    localparam logic [11:0] global_operating_modes_addr = 12'h008;
    localparam logic [11:0] global_clock_control_addr   = 12'h009;
    localparam logic [11:0] pll_lock_monitor_addr       = 12'h00A;
    localparam logic [11:0] configuration_commit_addr   = 12'h0FF;

    localparam logic [7:0] serial_port_config_reset     = 8'h18;
    localparam logic [7:0] speed_grade_select_reset     = 8'h00;
    localparam logic [7:0] target_mask_upper_reset      = 8'h0F;
    localparam logic [7:0] target_mask_lower_reset      = 8'h3F;
    localparam logic [7:0] global_operating_modes_reset = 8'h01;
    localparam logic [7:0] global_clock_control_reset   = 8'h01;
    localparam logic [7:0] pll_lock_monitor_reset       = 8'h00;
    // Identity value is arbitrary
    localparam logic [7:0] device_identity_value        = 8'h5B;

    localparam int lsb_first_hi_pos   = 6;
    localparam int lsb_first_lo_pos   = 1;
    localparam int soft_reset_hi_pos  = 5;
    localparam int soft_reset_lo_pos  = 2;
    localparam logic [7:0] port_config_fixed_ones = 8'h18;
    localparam logic [7:0] port_config_self_clear = 8'h3C;
    localparam int speed_field_lo     = 4;
    localparam int impedance_pos      = 6;
    localparam int pll_lock_pos       = 7;
    localparam int duty_cycle_pos     = 0;

    localparam int serial_cmd_bits    = 16;
    localparam int serial_frame_bits  = 24;

    typedef enum logic [1:0] {
        speed_40msps  = 2'b00,
        speed_65msps  = 2'b01,
        speed_80msps  = 2'b10,
        speed_125msps = 2'b11
    } speed_mode_type;

    typedef enum logic [2:0] {
        mode_time_gain      = 3'b000,
        mode_full_powerdown = 3'b001,
        mode_standby        = 3'b010,
        mode_link_reset     = 3'b011,
        mode_continuous_wave = 3'b100
    } operating_mode_type;

    // One register access gathered by the serial port
    typedef struct packed {
        logic        read;
        logic [11:0] addr;
        logic [7:0]  data;
    } access_type;

    // Settings that leave the bank for the rest of the chip
    typedef struct packed {
        speed_mode_type     speed_mode;
        operating_mode_type op_mode;
        logic               high_impedance_n;
        logic               duty_cycle_stabiliser;
        logic [9:0]         target_mask;
        logic               lsb_first;
        logic               link_regs_reset;
    } settings_type;
endpackage
`default_nettype wire

// ### core/serial_port_shift.sv
// Serial port shifter on the port clock: frames commands, drives read data
`default_nettype none
module serial_port_shift (
    // Core reset, released while the port clock stands still
    input  wire logic                        reset,
    // Port side
    input  wire logic                        sclk,
    input  wire logic                        cs_n,
    input  wire logic                        sdio_in,
    output logic                             sdio_out,
    output logic                             sdio_oe,
    // Bit order, already synchronised onto sclk by the caller domain value
    input  wire logic                        lsb_first,
    // Read data, stable while a read frame is in its data phase
    input  wire logic [7:0]                  rd_data,
    // Completed access, toggled once per frame
    output chip_config_pkg::access_type      acc,
    output logic                             acc_toggle
);
    logic [4:0]  bit_cnt_q;
    logic [15:0] cmd_q;
    logic [7:0]  data_q;
    logic [7:0]  rd_shift_q;
    logic [15:0] cmd_next;
    logic [15:0] cmd_use;

    assign cmd_next = {cmd_q[14:0], sdio_in};
    // LSB-first frames carry address bits low first; restore order here
    always_comb begin
        cmd_use = cmd_next;
        if (lsb_first) begin
            for (int i = 0; i < 16; i++) begin
                cmd_use[i] = cmd_next[15 - i];
            end
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= 5'h00;
            cmd_q     <= 16'h0000;
            data_q    <= 8'h00;
        end else begin
            if (bit_cnt_q != 5'(chip_config_pkg::serial_frame_bits)) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            if (bit_cnt_q < 5'(chip_config_pkg::serial_cmd_bits)) begin
                cmd_q <= cmd_next;
            end else if (bit_cnt_q < 5'(chip_config_pkg::serial_frame_bits)) begin
                data_q <= lsb_first ? {sdio_in, data_q[7:1]} : {data_q[6:0], sdio_in};
            end
        end
    end

    // Access word and its toggle; cmd_use is already in natural bit order
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            acc        <= '0;
            acc_toggle <= 1'b0;
        end else begin
            if (bit_cnt_q == 5'(chip_config_pkg::serial_cmd_bits - 1) && !cs_n) begin
                acc.read <= cmd_use[15];
                acc.addr <= cmd_use[11:0];
            end
            if (bit_cnt_q == 5'(chip_config_pkg::serial_frame_bits - 1) && !cs_n) begin
                acc.data   <= lsb_first ? {sdio_in, data_q[7:1]} : {data_q[6:0], sdio_in};
                acc_toggle <= ~acc_toggle;
            end
        end
    end

    // Read data is driven on falling edges during the data phase
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rd_shift_q <= 8'h00;
            sdio_out   <= 1'b0;
            sdio_oe    <= 1'b0;
        end else if (bit_cnt_q == 5'(chip_config_pkg::serial_cmd_bits) && acc.read) begin
            rd_shift_q <= lsb_first ? {1'b0, rd_data[7:1]} : {rd_data[6:0], 1'b0};
            sdio_out   <= lsb_first ? rd_data[0] : rd_data[7];
            sdio_oe    <= 1'b1;
        end else if (sdio_oe && bit_cnt_q < 5'(chip_config_pkg::serial_frame_bits)) begin
            rd_shift_q <= lsb_first ? {1'b0, rd_shift_q[7:1]} : {rd_shift_q[6:0], 1'b0};
            sdio_out   <= lsb_first ? rd_shift_q[0] : rd_shift_q[7];
        end else begin
            sdio_oe    <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### core/chip_config_bank.sv
// Chip configuration register bank behind the serial configuration port
// Notes on behaviour
// - Port config keeps only the mirrored bit-order bits 6,1; bits 4,3 read one; resets 0x18.
// - Soft reset returns every register except port config to default, link registers too.
// - After soft reset, port config bits 2 and 5 clear by themselves; bits 4,3 stay one.
// - Identity register is eight-bit read-only; writes ignored.
// - Speed bits 5:4 pick 40, 65, 80 or 125 MSPS; 40 is default.
// - Commit write reloads analog and converter defaults; keeps link, port config, speed.
// - Commit acts only if speed register written since last reset or defaults load.
// - Two masks pick targets of later local writes; defaults 0x0F and 0x3F.
// - Global modes bit 6 picks preamplifier impedance, zero 6k, one 3k.
// - PLL monitor bit 7 reports lock; read-only, default 0x00.
// - Device leaves power-up in full power-down mode.
// - Global clock bit 0 enables duty cycle stabiliser, default on, 0x01.
`default_nettype none
module chip_config_bank (
    // Core clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // Serial configuration port
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          sdio_in,
    output logic                               sdio_out,
    output logic                               sdio_oe,
    // Status from the chip
    input  wire logic                          pll_locked,
    // Settings to the chip
    output chip_config_pkg::settings_type      settings_q,
    output logic                               speed_commit_q
);
    chip_config_pkg::access_type acc;
    logic                        acc_toggle;
    logic [7:0]                  rd_data;
    // Readable registers, and their copies on the port clock
    logic [7:0]                  read_view [8];
    logic [7:0]                  view_sync1_q [8];
    logic [7:0]                  view_sync2_q [8];

    logic [7:0] port_config_q;
    logic [7:0] speed_q;
    logic [7:0] mask_upper_q;
    logic [7:0] mask_lower_q;
    logic [7:0] modes_q;
    logic [7:0] clock_ctrl_q;
    logic [7:0] pll_mon_q;
    logic       speed_written_q;
    logic [1:0] speed_active_q;

    // Sync of the port-side access toggle and the lock status into the core domain
    logic       acc_sync1_q;
    logic       acc_sync2_q;
    logic       acc_sync3_q;
    logic       acc_valid;
    chip_config_pkg::access_type acc_core_q;
    logic       acc_pending_q;
    logic       pll_sync1_q;
    logic       pll_sync2_q;
    // Bit order crossing into port domain
    logic       order_sync1_q;
    logic       order_sync2_q;

    logic       wr;
    logic       soft_reset_req;
    logic       commit_go;

    serial_port_shift port_shift (
        .reset       (reset),
        .sclk        (sclk),
        .cs_n        (cs_n),
        .sdio_in     (sdio_in),
        .sdio_out    (sdio_out),
        .sdio_oe     (sdio_oe),
        .lsb_first   (order_sync2_q),
        .rd_data     (rd_data),
        .acc         (acc),
        .acc_toggle  (acc_toggle)
    );

    // Bit order and register copies onto the port clock; values sit still during frames
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            order_sync1_q <= 1'b0;
            order_sync2_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                view_sync1_q[i] <= 8'h00;
                view_sync2_q[i] <= 8'h00;
            end
        end else begin
            order_sync1_q <= port_config_q[chip_config_pkg::lsb_first_hi_pos]
                           | port_config_q[chip_config_pkg::lsb_first_lo_pos];
            order_sync2_q <= order_sync1_q;
            view_sync1_q  <= read_view;
            view_sync2_q  <= view_sync1_q;
        end
    end

    // Toggle and lock synchronisers; first stage read only by second
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_sync1_q  <= 1'b0;
            acc_sync2_q  <= 1'b0;
            acc_sync3_q  <= 1'b0;
            pll_sync1_q  <= 1'b0;
            pll_sync2_q  <= 1'b0;
        end else begin
            acc_sync1_q  <= acc_toggle;
            acc_sync2_q  <= acc_sync1_q;
            acc_sync3_q  <= acc_sync2_q;
            pll_sync1_q  <= pll_locked;
            pll_sync2_q  <= pll_sync1_q;
        end
    end

    assign acc_valid = acc_sync2_q ^ acc_sync3_q;

    // Access word is stable for many port clocks after its toggle
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_core_q    <= '0;
            acc_pending_q <= 1'b0;
        end else begin
            acc_pending_q <= acc_valid;
            if (acc_valid) begin
                acc_core_q <= acc;
            end
        end
    end

    assign wr             = acc_pending_q && !acc_core_q.read;
    assign soft_reset_req = wr && acc_core_q.addr == chip_config_pkg::serial_port_config_addr
                          && (acc_core_q.data[chip_config_pkg::soft_reset_hi_pos]
                            | acc_core_q.data[chip_config_pkg::soft_reset_lo_pos]);
    assign commit_go      = wr && acc_core_q.addr == chip_config_pkg::configuration_commit_addr
                          && speed_written_q;

    // Port config: mirrored nibbles, fixed ones, self-clearing after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            port_config_q <= chip_config_pkg::serial_port_config_reset;
        end else if (soft_reset_req) begin
            port_config_q <= (port_config_q & ~chip_config_pkg::port_config_self_clear)
                           | chip_config_pkg::port_config_fixed_ones;
        end else if (wr && acc_core_q.addr == chip_config_pkg::serial_port_config_addr) begin
            port_config_q <= (acc_core_q.data & 8'h42) | chip_config_pkg::port_config_fixed_ones;
        end
    end

    // Speed field and written flag
    always_ff @(posedge clk) begin
        if (reset || soft_reset_req) begin
            speed_q         <= chip_config_pkg::speed_grade_select_reset;
            speed_written_q <= 1'b0;
        end else if (wr && acc_core_q.addr == chip_config_pkg::speed_grade_select_addr) begin
            speed_q         <= acc_core_q.data & 8'h30;
            speed_written_q <= 1'b1;
        end else if (commit_go) begin
            speed_written_q <= 1'b0;
        end
    end

    // Committed speed mode only moves on a valid commit, a reset or a soft reset
    always_ff @(posedge clk) begin
        if (reset || soft_reset_req) begin
            speed_active_q <= chip_config_pkg::speed_grade_select_reset[5:4];
            speed_commit_q <= 1'b0;
        end else begin
            speed_commit_q <= commit_go;
            if (commit_go) begin
                speed_active_q <= speed_q[chip_config_pkg::speed_field_lo +: 2];
            end
        end
    end

    // Masks, modes and clock control reload on commit as well
    always_ff @(posedge clk) begin
        if (reset || soft_reset_req || commit_go) begin
            mask_upper_q <= chip_config_pkg::target_mask_upper_reset;
            mask_lower_q <= chip_config_pkg::target_mask_lower_reset;
            modes_q      <= chip_config_pkg::global_operating_modes_reset;
            clock_ctrl_q <= chip_config_pkg::global_clock_control_reset;
        end else if (wr) begin
            unique case (acc_core_q.addr)
                chip_config_pkg::target_mask_upper_addr:      mask_upper_q <= acc_core_q.data & 8'h0F;
                chip_config_pkg::target_mask_lower_addr:      mask_lower_q <= acc_core_q.data & 8'h3F;
                chip_config_pkg::global_operating_modes_addr: modes_q <= acc_core_q.data & 8'h47;
                chip_config_pkg::global_clock_control_addr:   clock_ctrl_q <= acc_core_q.data & 8'h01;
                default: ;
            endcase
        end
    end

    // Lock status is sampled, never written
    always_ff @(posedge clk) begin
        if (reset || soft_reset_req) begin
            pll_mon_q <= chip_config_pkg::pll_lock_monitor_reset;
        end else begin
            pll_mon_q <= {pll_sync2_q, 7'h00};
        end
    end

    // Register values offered to reads; identity is constant
    assign read_view[0] = port_config_q;
    assign read_view[1] = chip_config_pkg::device_identity_value;
    assign read_view[2] = speed_q;
    assign read_view[3] = mask_upper_q;
    assign read_view[4] = mask_lower_q;
    assign read_view[5] = modes_q;
    assign read_view[6] = clock_ctrl_q;
    assign read_view[7] = pll_mon_q;

    // Read decode on the port clock, settled half a bit after the address completes
    always_comb begin
        unique case (acc.addr)
            chip_config_pkg::serial_port_config_addr:     rd_data = view_sync2_q[0];
            chip_config_pkg::device_identity_addr:        rd_data = view_sync2_q[1];
            chip_config_pkg::speed_grade_select_addr:     rd_data = view_sync2_q[2];
            chip_config_pkg::target_mask_upper_addr:      rd_data = view_sync2_q[3];
            chip_config_pkg::target_mask_lower_addr:      rd_data = view_sync2_q[4];
            chip_config_pkg::global_operating_modes_addr: rd_data = view_sync2_q[5];
            chip_config_pkg::global_clock_control_addr:   rd_data = view_sync2_q[6];
            chip_config_pkg::pll_lock_monitor_addr:       rd_data = view_sync2_q[7];
            default:                                      rd_data = 8'h00;
        endcase
    end

    // Settings out
    always_ff @(posedge clk) begin
        if (reset) begin
            settings_q <= '0;
            settings_q.op_mode <= chip_config_pkg::mode_full_powerdown;
            settings_q.duty_cycle_stabiliser <= 1'b1;
            settings_q.target_mask <= {chip_config_pkg::target_mask_upper_reset[3:0],
                                       chip_config_pkg::target_mask_lower_reset[5:0]};
        end else begin
            settings_q.speed_mode <= chip_config_pkg::speed_mode_type'(speed_active_q);
            settings_q.op_mode <= chip_config_pkg::operating_mode_type'(modes_q[2:0]);
            settings_q.high_impedance_n <= modes_q[chip_config_pkg::impedance_pos];
            settings_q.duty_cycle_stabiliser <= clock_ctrl_q[chip_config_pkg::duty_cycle_pos];
            settings_q.target_mask <= {mask_upper_q[3:0], mask_lower_q[5:0]};
            settings_q.lsb_first <= port_config_q[chip_config_pkg::lsb_first_hi_pos];
            settings_q.link_regs_reset <= soft_reset_req
                || modes_q[2:0] == chip_config_pkg::mode_link_reset;
        end
    end
endmodule
`default_nettype wire

// ### bench/chip_config_bank_props.sv
// Port assertions for the chip configuration register bank
`default_nettype none
module chip_config_bank_props (
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          reset,
    // Serial port
    input wire logic                          sclk,
    input wire logic                          cs_n,
    input wire logic                          sdio_in,
    input wire logic                          sdio_out,
    input wire logic                          sdio_oe,
    // Chip side
    input wire logic                          pll_locked,
    input wire chip_config_pkg::settings_type settings_q,
    input wire logic                          speed_commit_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Cycles left in which a commit or reset may still move the speed field
    logic [1:0] recent_q;
    always_ff @(posedge clk) begin
        if (reset || speed_commit_q || settings_q.link_regs_reset) recent_q <= 2'h3;
        else if (recent_q != 2'h0) recent_q <= recent_q - 2'h1;
    end

    pwrdn_at_start_a: assert property ($fell(reset) |->
        settings_q.op_mode == chip_config_pkg::mode_full_powerdown) else $error("not powered down");
    dcs_at_start_a: assert property ($fell(reset) |->
        settings_q.duty_cycle_stabiliser) else $error("stabiliser off after reset");
    mask_at_start_a: assert property ($fell(reset) |->
        settings_q.target_mask == 10'h3FF) else $error("mask default wrong");
    speed_at_start_a: assert property ($fell(reset) |->
        settings_q.speed_mode == chip_config_pkg::speed_40msps && !settings_q.high_impedance_n)
        else $error("speed or impedance default wrong");
    order_at_start_a: assert property ($fell(reset) |->
        !settings_q.lsb_first) else $error("bit order default wrong");
    commit_single_a: assert property (speed_commit_q |=> !speed_commit_q)
        else $error("commit pulse too long");
    commit_reload_a: assert property (speed_commit_q |-> ##[0:3]
        (settings_q.target_mask == 10'h3FF && settings_q.duty_cycle_stabiliser
         && settings_q.op_mode == chip_config_pkg::mode_full_powerdown))
        else $error("commit did not reload defaults");
    speed_moves_a: assert property ($changed(settings_q.speed_mode) |->
        recent_q != 2'h0 || speed_commit_q || settings_q.link_regs_reset)
        else $error("speed changed without commit");
    link_mode_a: assert property (
        (settings_q.op_mode == chip_config_pkg::mode_link_reset) [*2] |->
        settings_q.link_regs_reset) else $error("link reset level missing");
    soft_reset_a: assert property ($rose(settings_q.link_regs_reset) &&
        settings_q.op_mode != chip_config_pkg::mode_link_reset |-> ##[0:3]
        (settings_q.target_mask == 10'h3FF
         && settings_q.op_mode == chip_config_pkg::mode_full_powerdown
         && settings_q.speed_mode == chip_config_pkg::speed_40msps))
        else $error("soft reset did not load defaults");

    commit_seen_c: cover property (speed_commit_q);
    soft_reset_c: cover property ($rose(settings_q.link_regs_reset));
    top_speed_c: cover property (settings_q.speed_mode == chip_config_pkg::speed_125msps);
endmodule

bind chip_config_bank chip_config_bank_props i_props (
    .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .pll_locked(pll_locked),
    .settings_q(settings_q), .speed_commit_q(speed_commit_q)
);
`default_nettype wire

// ### bench/host_port_model.sv
// Host controller model driving the serial configuration port
`default_nettype none
module host_port_model (
    // Port pins
    output var logic  sclk,
    output var logic  cs_n,
    output wire logic sdio_in,
    input wire logic  sdio_out,
    input wire logic  sdio_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_bit;
    // Released line shows a toggling value, never the last one
    assign sdio_in = sdio_oe ? sdio_out : host_bit;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_bit = 1'b0;
    end
    // One 24-bit frame; clock stands still between frames
    task automatic xfer(input logic rd, input logic [11:0] addr, input logic [7:0] wd,
                        input logic lsb, output logic [7:0] rdv);
        logic [15:0] cmd;
        int k;
        cmd = {rd, 3'h0, addr};
        rdv = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < 24; i++) begin
            k = lsb ? (i < 16 ? i : i - 16) : (i < 16 ? 15 - i : 23 - i);
            host_bit = (i < 16) ? cmd[k] : (rd ? ~host_bit : wd[k]);
            #7.5 sclk = 1'b1;
            if (i >= 16) rdv[k] = sdio_in;
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        host_bit = ~host_bit;
        #60;
    endtask
endmodule
`default_nettype wire

// ### bench/tb_chip_config_bank.sv
// Testbench for the chip configuration register bank
`default_nettype none
module tb_chip_config_bank;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  data;
        logic [7:0]  exp;
    } row_type;
    logic                          clk = 1'b0;
    logic                          reset = 1'b1;
    logic                          pll_locked = 1'b0;
    wire logic                     sclk;
    wire logic                     cs_n;
    wire logic                     sdio_in;
    wire logic                     sdio_out;
    wire logic                     sdio_oe;
    chip_config_pkg::settings_type settings_q;
    logic                          speed_commit_q;
    logic                          lsb_mode = 1'b0;
    logic [7:0]                    rv;
    int                            fails = 0;
    int                            num_checks = 0;
    int                            commits = 0;
    row_type rows [13] = '{
        '{1'b0, 12'h000, 8'h00, 8'h18}, '{1'b0, 12'h002, 8'h00, 8'h00},
        '{1'b0, 12'h004, 8'h00, 8'h0F}, '{1'b0, 12'h005, 8'h00, 8'h3F},
        '{1'b0, 12'h008, 8'h00, 8'h01}, '{1'b0, 12'h009, 8'h00, 8'h01},
        '{1'b0, 12'h00A, 8'h00, 8'h00}, '{1'b1, 12'h001, 8'hFF, 8'h5B},
        '{1'b1, 12'h00A, 8'hFF, 8'h00}, '{1'b1, 12'h004, 8'h05, 8'h05},
        '{1'b1, 12'h005, 8'h2A, 8'h2A}, '{1'b1, 12'h008, 8'h42, 8'h42},
        '{1'b1, 12'h009, 8'h00, 8'h00}
    };

    always #2 clk = ~clk;
    always @(posedge clk) if (speed_commit_q === 1'b1) commits <= commits + 1;

    chip_config_bank i_dut (
        .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .pll_locked(pll_locked),
        .settings_q(settings_q), .speed_commit_q(speed_commit_q)
    );
    host_port_model i_host (
        .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic acc(input logic rd, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        i_host.xfer(rd, a, d, lsb_mode, rv);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] want);
        acc(1'b1, a, 8'h00);
        check(16'(rv), 16'(want));
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        wrap_up;
    end

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check(16'(settings_q.op_mode), 16'h1);
        check(16'(settings_q.duty_cycle_stabiliser), 16'h1);
        foreach (rows[i]) begin
            if (rows[i].wr) acc(1'b0, rows[i].addr, rows[i].data);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        check(16'(settings_q.target_mask), 16'h16A);
        check(16'(settings_q.high_impedance_n), 16'h1);
        // Commit before any speed write must do nothing
        acc(1'b0, 12'h0FF, 8'h01);
        rd_chk(12'h004, 8'h05);
        check(16'(commits), 16'h0);
        for (int s = 0; s < 4; s++) begin
            acc(1'b0, 12'h002, 8'(s << 4));
            check(16'(settings_q.speed_mode), 16'(s == 0 ? 0 : s - 1));
            acc(1'b0, 12'h0FF, 8'h01);
            check(16'(settings_q.speed_mode), 16'(s));
            check(16'(commits), 16'(s + 1));
        end
        rd_chk(12'h002, 8'h30);
        rd_chk(12'h004, 8'h0F);
        rd_chk(12'h009, 8'h01);
        // A second commit after the defaults load is refused
        acc(1'b0, 12'h004, 8'h05);
        acc(1'b0, 12'h0FF, 8'h01);
        rd_chk(12'h004, 8'h05);
        check(16'(commits), 16'h4);
        @(posedge clk) pll_locked <= 1'b1;
        rd_chk(12'h00A, 8'h80);
        for (int m = 0; m < 5; m++) begin
            acc(1'b0, 12'h008, 8'(m));
            check(16'(settings_q.op_mode), 16'(m));
            check(16'(settings_q.link_regs_reset), 16'(m == 3));
        end
        // Soft reset with both mirrored bits
        acc(1'b0, 12'h000, 8'h24);
        rd_chk(12'h000, 8'h18);
        rd_chk(12'h002, 8'h00);
        rd_chk(12'h008, 8'h01);
        rd_chk(12'h004, 8'h0F);
        // Switch to least significant bit first and back
        acc(1'b0, 12'h000, 8'h42);
        check(16'(settings_q.lsb_first), 16'h1);
        lsb_mode = 1'b1;
        rd_chk(12'h000, 8'h5A);
        acc(1'b0, 12'h004, 8'h03);
        rd_chk(12'h004, 8'h03);
        acc(1'b0, 12'h000, 8'h00);
        lsb_mode = 1'b0;
        rd_chk(12'h000, 8'h18);
        wrap_up;
    end
endmodule
`default_nettype wire
